//--- logic/dac_cmd_pkg.sv
// Purpose: Shared constants and types for the quad DAC serial command decoder
// Assumes: 125 MHz system clock, serial pins sampled into that domain
// Notes: Command codes are {channel_select_high, channel_select_low, control_bit_high, control_bit_low}
`default_nettype none
package dac_cmd_pkg;
   // Word layout
   localparam int WORD_BITS = 12;
   localparam int DATA_BITS = 8;
   localparam int CODE_MSB = 11;
   localparam int CODE_LSB = 8;
   localparam int CHANNELS = 4;
   // Command codes, {sel_hi, sel_lo, ctl_hi, ctl_lo}
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_XFER = 4'h4;
   localparam logic [3:0] CMD_LOAD_ALL = 4'h8;
   localparam logic [3:0] CMD_SHUTDOWN = 4'hC;
   localparam logic [3:0] CMD_UPO_LOW = 4'h2;
   localparam logic [3:0] CMD_UPO_HIGH = 4'h6;
   localparam logic [3:0] CMD_PHASE_RISE = 4'hE;
   localparam logic [3:0] CMD_PHASE_FALL = 4'hA;
   localparam logic [1:0] CTL_LOAD_INPUT = 2'h1;
   localparam logic [1:0] CTL_LOAD_UPDATE = 2'h3;
   // Reset values
   localparam logic [7:0] DAC_RESET = 8'h00;
   localparam logic [11:0] SHIFT_RESET = 12'h000;
   localparam logic PHASE_RESET = 1'b0; // 0 falling edge, 1 rising edge
   localparam logic [4:0] PIN_SYNC_RESET = 5'h1E; // Strobe, clear, permit, cs_n high, sclk low
   localparam logic [1:0] EDGE_HIST_RESET = 2'h1; // Previous sclk low, previous cs_n high
   // Command FIFO depth
   localparam int FIFO_DEPTH = 8;
   // Decoded command word as carried through the FIFO
   typedef struct packed {
      logic [1:0] chan;
      logic [1:0] ctl;
      logic [7:0] data;
   } cmd_word_t;
   // Four DAC bytes
   typedef struct packed {
      logic [7:0] d;
      logic [7:0] c;
      logic [7:0] b;
      logic [7:0] a;
   } dac_bank_t;
endpackage
`default_nettype wire

//--- logic/cmd_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes: Depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic clock_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic in_valid_i, // Write request
   output logic in_ready_o, // Not full
   input wire logic [WIDTH-1:0] in_data_i, // Write data
   output logic out_valid_o, // Not empty
   input wire logic out_ready_i, // Read accept
   output logic [WIDTH-1:0] out_data_o // Head word
);
   localparam int AW = $clog2(DEPTH);
   // Elaboration check: pointer wrap needs a power-of-two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("cmd_fifo: DEPTH must be power of two >= 2");
   end
   logic [WIDTH-1:0] mem [DEPTH]; // Storage
   logic [AW:0] wr_ptr; // Write pointer with wrap bit
   logic [AW:0] rd_ptr; // Read pointer with wrap bit
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic push, pop;
   ////////////////////////////////////////////////////////////////////
   // Flags and next pointers
   always_comb begin
      in_ready_o = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
      out_valid_o = wr_ptr != rd_ptr;
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      out_data_o = mem[rd_ptr[AW-1:0]];
   end
   // Pointer registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end
   // Storage write
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule // cmd_fifo
`default_nettype wire

//--- logic/quad_dac_serial_command_decoder.sv
// Purpose: Serial command decoder for a four-channel 8-bit DAC
// Assumes: Serial pins and strobes are asynchronous, sampled by two flip-flops
// Notes: Captured words queue in a FIFO; the executor drains one every two cycles
//        A full queue drops the word and sets the sticky overflow flag
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_command_decoder
   import dac_cmd_pkg::*;
#(
   parameter int FIFO_WORDS = dac_cmd_pkg::FIFO_DEPTH
) (
   input wire logic clock_i, // 125 MHz system clock
   input wire logic rst_n_i, // Power-on clear, async, active low
   input wire logic serial_clock_i, // Serial clock pin
   input wire logic chip_select_n_i, // Chip select pin, active low
   input wire logic serial_in_i, // Serial data input pin
   input wire logic load_strobe_n_i, // Load strobe pin, active low
   input wire logic hard_clear_n_i, // Hardware clear pin, active low
   input wire logic powerdown_permit_i, // Shutdown permit pin
   output logic serial_out_o, // Serial data output
   output logic user_logic_output_o, // User logic output
   output logic shutdown_o, // Output buffers shut down
   output logic rising_phase_o, // Output phase, 1 rising
   output dac_cmd_pkg::dac_bank_t input_regs_o, // Input registers
   output dac_cmd_pkg::dac_bank_t dac_regs_o, // DAC registers
   output logic cmd_overflow_o // Word lost, FIFO full
);
   ////////////////////////////////////////////////////////////////////
   // Elaboration check: the queue needs a power-of-two depth of two or more
   if (FIFO_WORDS < 2 || (1 << $clog2(FIFO_WORDS)) != FIFO_WORDS) begin : g_bad_fifo_words
      $error("FIFO_WORDS must be a power of two, at least 2");
   end
   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Edges are only seen if the serial clock stays high and low
   // for at least one system clock each
   logic [4:0] sync_a; // First stage
   logic [4:0] sync_b; // Second stage
   logic [1:0] hist; // Previous sclk, cs_n
   // Two flip-flops per pin, then one more for edge history
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_a <= PIN_SYNC_RESET;
         sync_b <= PIN_SYNC_RESET;
         hist <= EDGE_HIST_RESET;
      end else begin
         sync_a <= {load_strobe_n_i, hard_clear_n_i, powerdown_permit_i,
                    chip_select_n_i, serial_clock_i};
         sync_b <= sync_a;
         hist <= {sync_b[0], sync_b[1]};
      end
   end
   logic sclk_s; // Serial clock, synchronised
   logic cs_n_s; // Chip select, synchronised
   logic permit_s; // Shutdown permit, synchronised
   logic clear_n_s; // Hardware clear, synchronised
   logic load_n_s; // Load strobe, synchronised
   logic sclk_rise; // One-cycle pulse, serial clock rose
   logic sclk_fall; // One-cycle pulse, serial clock fell
   logic cs_rise; // One-cycle pulse, chip select released
   // Synchronised levels and edge pulses
   always_comb begin
      sclk_s = sync_b[0];
      cs_n_s = sync_b[1];
      permit_s = sync_b[2];
      clear_n_s = sync_b[3];
      load_n_s = sync_b[4];
      sclk_rise = sclk_s && !hist[1];
      sclk_fall = !sclk_s && hist[1];
      cs_rise = cs_n_s && !hist[0];
   end
   // Data pin synchroniser, aligned with the clock sample
   logic din_a, din_b;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         din_a <= 1'b0;
         din_b <= 1'b0;
      end else begin
         din_a <= serial_in_i;
         din_b <= din_a;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Shift register and serial output
   // The bit pushed out by a rise is kept, so that the falling phase
   // can present that same bit half a serial period later.
   logic [11:0] shift_reg; // Last twelve bits in
   logic [11:0] next_shift_reg; // Shift register next value
   logic leaving_bit, next_leaving_bit; // Bit pushed out by the last rise
   logic serial_out, next_serial_out; // Registered output level
   logic rising_phase, next_rising_phase; // Output phase, owned by executor
   // Next shift contents, leaving bit and output level
   always_comb begin
      next_shift_reg = shift_reg;
      next_leaving_bit = leaving_bit;
      next_serial_out = serial_out;
      if (!clear_n_s) begin
         // Hard clear empties the shift register
         next_shift_reg = SHIFT_RESET;
      end else if (!cs_n_s) begin
         // Only a selected device shifts or moves its output
         if (sclk_rise) begin
            next_shift_reg = {shift_reg[WORD_BITS-2:0], din_b};
            next_leaving_bit = shift_reg[WORD_BITS-1];
         end
         if (rising_phase && sclk_rise) begin
            // Rising phase: leaving bit goes out at once, lag 12
            next_serial_out = shift_reg[WORD_BITS-1];
         end else if (!rising_phase && sclk_fall) begin
            // Falling phase: same bit half a cycle later, lag 12.5
            next_serial_out = leaving_bit;
         end
      end
   end
   // Shift and output registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_reg <= SHIFT_RESET;
         leaving_bit <= 1'b0;
         serial_out <= 1'b0;
      end else begin
         shift_reg <= next_shift_reg;
         leaving_bit <= next_leaving_bit;
         serial_out <= next_serial_out;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Word capture into FIFO, one push per chip-select rising edge
   cmd_word_t cap_word; // Shift contents at chip-select release
   cmd_word_t head_word; // Oldest queued word
   logic push; // Capture strobe
   logic fifo_ready; // Queue has room
   logic head_valid; // Queue holds a word
   logic pop; // Executor takes the head word
   // Capture the word once per release
   always_comb begin
      cap_word = cmd_word_t'(shift_reg);
      push = cs_rise;
   end
   // Queue decouples capture from execution
   cmd_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i(cap_word),
      .out_valid_o(head_valid),
      .out_ready_i(pop),
      .out_data_o(head_word)
   );
   ////////////////////////////////////////////////////////////////////
   // Executor state machine
   // One-hot states: wait for a word, then run it
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } exec_state_t;
   exec_state_t state, next_state;
   dac_bank_t in_regs, next_in_regs;
   dac_bank_t dac_regs, next_dac_regs;
   logic shutdown, next_shutdown;
   logic user_logic_output, next_upo;
   logic overflow, next_overflow;
   logic [3:0] code;
   logic xfer_all; // Copy all input registers to DAC registers
   // Queued words wait while the hard clear is low, so a command
   // queued before a clear still runs once the clear lifts
   // Next values for the executor and the registers it owns
   always_comb begin
      next_state = state;
      next_in_regs = in_regs;
      next_dac_regs = dac_regs;
      next_shutdown = shutdown;
      next_upo = user_logic_output;
      next_rising_phase = rising_phase;
      next_overflow = overflow || (push && !fifo_ready);
      code = {head_word.chan, head_word.ctl};
      xfer_all = 1'b0;
      pop = 1'b0;
      unique case (state)
         ST_IDLE: begin
            // Hold off execution while the hardware clear is low
            if (head_valid && clear_n_s) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            pop = 1'b1;
            next_state = ST_IDLE;
            if (head_word.ctl == CTL_LOAD_INPUT || head_word.ctl == CTL_LOAD_UPDATE) begin
               // Single-channel load, select decoded A..D
               unique case (head_word.chan)
                  2'h0: next_in_regs.a = head_word.data;
                  2'h1: next_in_regs.b = head_word.data;
                  2'h2: next_in_regs.c = head_word.data;
                  2'h3: next_in_regs.d = head_word.data;
               endcase
               xfer_all = head_word.ctl == CTL_LOAD_UPDATE;
            end else begin
               // Data byte unused below except load-all
               unique case (code)
                  CMD_XFER: begin
                     xfer_all = 1'b1;
                     next_shutdown = 1'b0;
                  end
                  CMD_LOAD_ALL: begin
                     next_in_regs = '0;
                     next_dac_regs = {CHANNELS{head_word.data}};
                     next_shutdown = 1'b0;
                  end
                  CMD_SHUTDOWN: begin
                     if (permit_s) begin
                        next_shutdown = 1'b1;
                     end
                  end
                  CMD_UPO_LOW: next_upo = 1'b0;
                  CMD_UPO_HIGH: next_upo = 1'b1;
                  CMD_PHASE_RISE: begin
                     next_rising_phase = 1'b1;
                     xfer_all = 1'b1;
                  end
                  CMD_PHASE_FALL: begin
                     next_rising_phase = 1'b0;
                     xfer_all = 1'b1;
                  end
                  default: ;
               endcase
            end
            if (code == CMD_LOAD_ALL) begin
               next_in_regs = in_regs; // Load-all leaves input registers alone
            end
         end
         default: next_state = ST_IDLE;
      endcase
      if (xfer_all) begin
         next_dac_regs = next_in_regs;
      end
      // Transparent DAC registers while strobe low
      if (!load_n_s) begin
         next_dac_regs = next_in_regs;
      end
      // Hardware clear overrides the input and DAC register values
      if (!clear_n_s) begin
         next_in_regs = '0;
         next_dac_regs = '0;
      end
   end
   // Executor registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         in_regs <= '0;
         dac_regs <= '0;
         shutdown <= 1'b0;
         user_logic_output <= 1'b0;
         rising_phase <= PHASE_RESET;
         overflow <= 1'b0;
      end else begin
         state <= next_state;
         in_regs <= next_in_regs;
         dac_regs <= next_dac_regs;
         shutdown <= next_shutdown;
         user_logic_output <= next_upo;
         rising_phase <= next_rising_phase;
         overflow <= next_overflow;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops
   always_comb begin
      serial_out_o = serial_out;
      user_logic_output_o = user_logic_output;
      shutdown_o = shutdown;
      rising_phase_o = rising_phase;
      input_regs_o = in_regs;
      dac_regs_o = dac_regs;
      cmd_overflow_o = overflow;
   end
endmodule // quad_dac_serial_command_decoder
`default_nettype wire

//--- tb/dac_host_model.sv
// Purpose: Behavioural host serial controller driving the decoder's serial pins
// Assumes: Serial clock period 80 ns, idle low, stopped between frames
// Notes: Reads the device serial output late in each low half of the serial clock
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
   input wire logic serial_out_i, // Device serial output
   output var logic serial_clock_o, // Serial clock, idles low
   output var logic chip_select_n_o, // Chip select, active low
   output var logic serial_in_o // Serial data to the device
);
   logic [31:0] seen = 32'h0; // Bits read back from the device
   ////////////////////////////////////////////////////////////////////////////////
   // Idle levels at time zero
   initial begin
      serial_clock_o = 1'b0;
      chip_select_n_o = 1'b1;
      serial_in_o = 1'b0;
   end
   // One frame, last n bits of w, most significant first; the output is read
   // late in each low half, where both output phases have settled
   task automatic frame(input logic [23:0] w, input int n);
      chip_select_n_o = 1'b0;
      #50;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in_o = w[i];
         #37 seen = {seen[30:0], serial_out_i};
         #3 serial_clock_o = 1'b1;
         #40 serial_clock_o = 1'b0;
      end
      // Last read after the final fall, then release chip select
      #37 seen = {seen[30:0], serial_out_i};
      #3 chip_select_n_o = 1'b1;
      // Released data line shows the inverse, not a stale level
      serial_in_o = ~serial_in_o;
   endtask
endmodule // dac_host_model
`default_nettype wire

//--- tb/dac_cmd_checker.sv
// Purpose: Concurrent checks on the decoder's ports
// Assumes: Commands spaced far apart, no words queued across a hard clear
// Notes: Command effects must land within a short window after chip select rises
`timescale 1ns/1ps
`default_nettype none
module dac_cmd_checker #(
   parameter int FIFO_WORDS = 8
) (
   input wire logic clock_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic chip_select_n_i, // Chip select pin
   input wire logic load_strobe_n_i, // Load strobe pin
   input wire logic hard_clear_n_i, // Hardware clear pin
   input wire logic powerdown_permit_i, // Shutdown permit pin
   input wire logic serial_out_o, // Serial data output
   input wire logic user_logic_output_o, // User logic output
   input wire logic shutdown_o, // Shutdown state
   input wire logic rising_phase_o, // Output phase
   input wire dac_cmd_pkg::dac_bank_t input_regs_o, // Input registers
   input wire dac_cmd_pkg::dac_bank_t dac_regs_o // DAC registers
);
   import dac_cmd_pkg::*;
   localparam int LO = 2; // Earliest effect after chip select rise
   localparam int HI = 10; // Latest effect after chip select rise
   logic cs_q; // Chip select one cycle back
   logic [7:0] since_cs, next_since_cs; // Cycles since chip select rose
   logic [7:0] since_clr, next_since_clr; // Cycles since hard clear low
   ////////////////////////////////////////////////////////////////////////////////
   // Saturating age counters
   always_comb begin
      next_since_cs = since_cs + ((since_cs != 8'hFF) ? 8'h01 : 8'h00);
      next_since_clr = since_clr + ((since_clr != 8'hFF) ? 8'h01 : 8'h00);
      if (chip_select_n_i && !cs_q) next_since_cs = 8'h00;
      if (!hard_clear_n_i) next_since_clr = 8'h00;
   end
   // Register the counters
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_q <= 1'b1;
         since_cs <= 8'hFF;
         since_clr <= 8'hFF;
      end else begin
         cs_q <= chip_select_n_i;
         since_cs <= next_since_cs;
         since_clr <= next_since_clr;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   chk_phase_only_cmd: assert property ($changed(rising_phase_o) |->
      since_cs inside {[LO:HI]}) else $error("phase changed outside a command");
   chk_upo_only_cmd: assert property ($changed(user_logic_output_o) |->
      since_cs inside {[LO:HI]}) else $error("user output changed outside a command");
   chk_sd_persists: assert property ($changed(shutdown_o) |->
      since_cs inside {[LO:HI]}) else $error("shutdown changed outside a command");
   chk_sd_permit: assert property ($rose(shutdown_o) |->
      $past(powerdown_permit_i, 3)) else $error("shutdown entered without permit");
   chk_dac_transparent: assert property ((!load_strobe_n_i &&
      $stable(input_regs_o))[*6] ##0 since_cs > 8'h0C |-> dac_regs_o == input_regs_o)
      else $error("DAC registers not following input registers");
   chk_input_once: assert property ($changed(input_regs_o) |->
      since_cs inside {[LO:HI]} || since_clr <= 8'h06) else $error("input registers changed late");
   chk_dout_hold: assert property ((chip_select_n_i && hard_clear_n_i)[*8] |->
      $stable(serial_out_o)) else $error("serial output moved while deselected");
   chk_reset_zero: assert property ($rose(rst_n_i) |-> input_regs_o == '0 &&
      dac_regs_o == '0 && !rising_phase_o && !shutdown_o) else $error("bad state after reset");
endmodule // dac_cmd_checker
bind quad_dac_serial_command_decoder dac_cmd_checker #(.FIFO_WORDS(FIFO_WORDS)) chk (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .chip_select_n_i(chip_select_n_i),
   .load_strobe_n_i(load_strobe_n_i), .hard_clear_n_i(hard_clear_n_i),
   .powerdown_permit_i(powerdown_permit_i), .serial_out_o(serial_out_o),
   .user_logic_output_o(user_logic_output_o), .shutdown_o(shutdown_o),
   .rising_phase_o(rising_phase_o), .input_regs_o(input_regs_o), .dac_regs_o(dac_regs_o));
`default_nettype wire

//--- tb/quad_dac_serial_command_decoder_test.sv
// Purpose: Self-checking bench for the quad DAC serial command decoder
// Assumes: One command per frame, outputs settled 12 cycles after chip select
// Notes: Expected register state is kept in the bench and updated per command
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_command_decoder_test;
   import dac_cmd_pkg::*;
   logic clock_i = 1'b0; // System clock
   logic rst_n_i = 1'b0; // Reset, active low
   logic load_strobe_n_i = 1'b1; // Held high except in transparency test
   logic hard_clear_n_i = 1'b1; // Hardware clear
   logic powerdown_permit_i = 1'b0; // Shutdown permit
   logic serial_clock_i, chip_select_n_i, serial_in_i; // Driven by the host model
   logic serial_out_o, user_logic_output_o, shutdown_o, rising_phase_o, cmd_overflow_o;
   dac_bank_t input_regs_o, dac_regs_o, exp_in, exp_dac; // Observed and expected banks
   logic exp_upo, exp_sd, exp_ph; // Expected flags
   int miscompares = 0, n_compared = 0, cycles = 0;
   ////////////////////////////////////////////////////////////////////////////////
   quad_dac_serial_command_decoder dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .serial_clock_i(serial_clock_i), .chip_select_n_i(chip_select_n_i),
      .serial_in_i(serial_in_i), .load_strobe_n_i(load_strobe_n_i),
      .hard_clear_n_i(hard_clear_n_i), .powerdown_permit_i(powerdown_permit_i),
      .serial_out_o(serial_out_o), .user_logic_output_o(user_logic_output_o),
      .shutdown_o(shutdown_o), .rising_phase_o(rising_phase_o), .input_regs_o(input_regs_o),
      .dac_regs_o(dac_regs_o), .cmd_overflow_o(cmd_overflow_o));
   dac_host_model host (.serial_out_i(serial_out_o), .serial_clock_o(serial_clock_i),
      .chip_select_n_o(chip_select_n_i), .serial_in_o(serial_in_i));
   // Clock and hang guard
   always #4 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Compare every output except the serial output with the expected copy
   task automatic check_state();
      cmp_val(input_regs_o, exp_in);
      cmp_val(dac_regs_o, exp_dac);
      cmp_val({29'h0, user_logic_output_o, shutdown_o, rising_phase_o},
         {29'h0, exp_upo, exp_sd, exp_ph});
      cmp_val({31'h0, cmd_overflow_o}, 32'h0);
   endtask
   // Send one frame, let the command land, then compare
   task automatic send(input logic [11:0] w, input logic [11:0] pre = 12'h000,
      input int n = 12);
      @(posedge clock_i);
      #3;
      host.frame({pre, w}, n);
      repeat (12) @(posedge clock_i);
      #1;
      check_state();
   endtask
   // Daisy-chain frame: farthest word first, then a no-op word
   task automatic chain();
      send(12'h000, 12'h0A5, 24);
      cmp_val({20'h0, host.seen[11:0]}, 32'h0A5);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {exp_in, exp_dac, exp_upo, exp_sd, exp_ph} = '0;
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      #1;
      check_state();
      chain();
      for (int ch = 0; ch < CHANNELS; ch++) begin
         exp_in[ch*8 +: 8] = 8'h31 + 8'(ch);
         send({2'(ch), CTL_LOAD_INPUT, 8'h31 + 8'(ch)});
      end
      exp_dac = exp_in;
      send({CMD_XFER, 8'hFF});
      exp_in.c = 8'h7E;
      exp_dac = exp_in;
      send({2'h2, CTL_LOAD_UPDATE, 8'h7E});
      exp_dac = {4{8'h5A}};
      send({CMD_LOAD_ALL, 8'h5A});
      send({CMD_SHUTDOWN, 8'h00});
      @(posedge clock_i) powerdown_permit_i <= 1'b1;
      exp_sd = 1'b1;
      send({CMD_SHUTDOWN, 8'hA5});
      exp_upo = 1'b1;
      send({CMD_UPO_HIGH, 8'h00});
      exp_upo = 1'b0;
      send({CMD_UPO_LOW, 8'hFF});
      send({CMD_NOP, 8'hC3});
      {exp_sd, exp_dac} = '0;
      send({CMD_LOAD_ALL, 8'h00});
      exp_sd = 1'b1;
      send({CMD_SHUTDOWN, 8'h00});
      exp_sd = 1'b0;
      exp_dac = exp_in;
      send({CMD_XFER, 8'h00});
      exp_dac = {4{8'h11}};
      send({CMD_LOAD_ALL, 8'h11});
      exp_ph = 1'b1;
      exp_dac = exp_in;
      send({CMD_PHASE_RISE, 8'h96});
      chain();
      exp_in.a = 8'h9C;
      send({2'h0, CTL_LOAD_INPUT, 8'h9C});
      exp_ph = 1'b0;
      exp_dac = exp_in;
      send({CMD_PHASE_FALL, 8'h3C});
      exp_in.b = 8'hE7;
      send({2'h1, CTL_LOAD_INPUT, 8'hE7}, 12'h00F, 16);
      @(posedge clock_i) load_strobe_n_i <= 1'b0;
      exp_in.d = 8'h4B;
      exp_dac = exp_in;
      send({2'h3, CTL_LOAD_INPUT, 8'h4B});
      @(posedge clock_i) load_strobe_n_i <= 1'b1;
      @(posedge clock_i) hard_clear_n_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      hard_clear_n_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      #1;
      {exp_in, exp_dac} = '0;
      check_state();
      tally_and_finish();
   end
endmodule // quad_dac_serial_command_decoder_test
`default_nettype wire
